/* rx_gpio_pkg.sv */
// constants, types and state layouts for the receive-port gpio block
// assumes one 200 mhz core clock that also carries the link framing
package rx_gpio_pkg;

  localparam int NUM_PORTS = 2;
  localparam int NUM_PINS = 7;
  localparam int NUM_SLOTS = 4;

  // register offsets
  localparam logic [7:0] ADDR_PIN_IN_DIS = 8'h0f;
  localparam logic [7:0] ADDR_SLOT_A = 8'h6e;
  localparam logic [7:0] ADDR_SLOT_B = 8'h6f;
  localparam logic [7:0] ADDR_FRAMING_POL = 8'h7c;
  localparam logic [7:0] ADDR_FV_MIN = 8'hbc;
  localparam logic [7:0] ADDR_PIN_PD_DIS = 8'hbe;

  // reset values
  localparam logic [7:0] RST_FV_MIN = 8'h80;
  localparam logic [6:0] RST_PIN_IN_DIS = 7'h00;
  localparam logic [6:0] RST_PIN_PD_DIS = 7'h00;

  // polarity fields and slot source codes
  localparam int POL_FV_BIT = 0;
  localparam int POL_LV_BIT = 1;
  localparam int SLOT_SEL_W = 4;
  localparam logic [3:0] SRC_LAST_PIN = 4'h6;
  localparam logic [3:0] SRC_INT_SYNC = 4'h7;
  localparam logic [3:0] SRC_EXT_SYNC = 4'h8;

  // back channel frame timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BC_BIT_NS = 20;
  localparam int BC_FRAME_BITS = 30;
  localparam int BC_FRAME_NS = BC_BIT_NS * BC_FRAME_BITS;
  localparam int BC_FRAME_CYC = BC_FRAME_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [6:0] BC_FRAME_LAST = 7'(BC_FRAME_CYC - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic port;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic vsync;
    logic hsync;
  } raw_sync_s;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
  } framing_s;

  typedef enum logic [1:0] {QF_IDLE, QF_SETUP, QF_LINES, QF_DROP} qual_e;

  typedef struct packed {
    qual_e st;
    logic [7:0] cnt;
    logic fv_q;
    logic lv_q;
    framing_s out;
    logic err;
  } qual_state_s;

  typedef struct packed {
    logic [6:0] in_dis;
    logic [6:0] pd_dis;
    logic [6:0] pd_en;
    logic [6:0] in_en;
    logic [6:0] oe_n;
    logic [6:0] pin_out;
    logic [NUM_PORTS-1:0][7:0] slot_a;
    logic [NUM_PORTS-1:0][7:0] slot_b;
    logic [NUM_PORTS-1:0][1:0] pol;
    logic [7:0] fv_min;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic xfs_s1;
    logic xfs_s2;
    logic [6:0] frm_cnt;
    logic strobe;
    logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] slots;
  } main_state_s;

endpackage : rx_gpio_pkg

/* rx_frame_qualify.sv */
// frame-valid / line-valid qualifier for one receive port
// assumes raw sync inputs already on core_clk from the link decoder
`timescale 1ns/1ps
module rx_frame_qualify (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // raw framing in
  input wire rx_gpio_pkg::raw_sync_s raw_in,
  // controls
  input wire logic fv_pol,
  input wire logic lv_pol,
  input wire logic [7:0] min_count,
  input wire logic drop_short,
  // qualified framing out
  output rx_gpio_pkg::framing_s framing_out,
  output logic setup_err
);
  import rx_gpio_pkg::*;

  qual_state_s q;
  qual_state_s d;
  logic fv;
  logic lv;
  logic fv_rise;
  logic lv_rise;
  logic short_setup;

  // polarity applied before any edge detection
  assign fv = raw_in.vsync ^ fv_pol;
  assign lv = raw_in.hsync ^ lv_pol;
  assign fv_rise = fv && !q.fv_q;
  assign lv_rise = lv && !q.lv_q;
  // a line starting with the frame edge has zero setup
  assign short_setup = fv_rise || (q.cnt < min_count);

  // next state: setup count, first-line check, line gating
  always_comb begin
    d = q;
    d.err = 1'b0;
    d.fv_q = fv;
    d.lv_q = lv;
    if (fv_rise) begin
      d.cnt = 8'h00;
    end else if (q.cnt != 8'hff) begin
      d.cnt = q.cnt + 8'h01; // saturates, threshold tops at 255
    end
    unique case (q.st)
      QF_IDLE: begin
        if (fv_rise) begin
          d.st = QF_SETUP;
        end
      end
      QF_SETUP: begin
        if (!fv) begin
          d.st = QF_IDLE;
        end
      end
      QF_LINES: begin
        if (!fv) begin
          d.st = QF_IDLE;
        end
      end
      QF_DROP: begin
        if (!fv) begin
          d.st = QF_IDLE;
        end else if (!lv) begin
          d.st = QF_LINES;
        end
      end
    endcase
    // first line of the frame is judged at its leading edge
    if (fv && lv_rise && (q.st == QF_SETUP || fv_rise)) begin
      if (short_setup) begin
        d.err = 1'b1;
        d.st = drop_short ? QF_DROP : QF_LINES;
      end else begin
        d.st = QF_LINES;
      end
    end
    d.out.frame_valid = fv;
    d.out.line_valid = fv && lv && (d.st == QF_LINES);
  end

  // state register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign framing_out = q.out;
  assign setup_err = q.err;

  chk_short_line_dropped: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (q.st == QF_SETUP && fv && lv_rise && short_setup && drop_short)
      |=> !framing_out.line_valid && setup_err)
    else $error("short first line was not dropped");

  chk_short_line_forwarded: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (q.st == QF_SETUP && fv && lv_rise && short_setup && !drop_short)
      |=> framing_out.line_valid && setup_err)
    else $error("short first line was not forwarded");

  chk_setup_accept: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (q.st == QF_SETUP && fv && lv_rise && !short_setup)
      |=> framing_out.line_valid && !setup_err)
    else $error("good setup first line not passed");

  chk_frame_polarity: assert property (
    @(posedge core_clk) disable iff (!rstn)
    // skip the first edge after release, the register was still in reset
    (rstn && $past(rstn))
      |-> framing_out.frame_valid == $past(raw_in.vsync ^ fv_pol))
    else $error("frame valid does not follow vsync polarity");

  chk_count_restart: assert property (
    @(posedge core_clk) disable iff (!rstn)
    fv_rise |=> q.cnt == 8'h00 ##1 q.cnt == 8'h01)
    else $error("setup counter did not restart on new frame");

  cov_short_drop: cover property (
    @(posedge core_clk) disable iff (!rstn)
    q.st == QF_DROP ##1 q.st == QF_LINES);

  cov_good_frame: cover property (
    @(posedge core_clk) disable iff (!rstn)
    q.st == QF_SETUP ##1 q.st == QF_LINES && !q.err);

endmodule : rx_frame_qualify

/* rx_port_gpio.sv */
// back channel gpio slot mapping, pin controls and framing per port
// assumes a byte register port from the control interface on core_clk
`timescale 1ns/1ps
module rx_port_gpio (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire rx_gpio_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // gpio pins
  input wire logic [6:0] gpio_in,
  output logic [6:0] gpio_out,
  output logic [6:0] gpio_oe_n,
  output logic [6:0] pin_input_en,
  output logic [6:0] pin_pulldown_en,
  // frame sync sources
  input wire logic int_frame_sync,
  input wire logic ext_frame_sync,
  // back channel slot samples
  output logic bc_frame_strobe,
  output logic [1:0][3:0] bc_slots,
  // raw framing per port
  input wire rx_gpio_pkg::raw_sync_s [1:0] raw_in,
  input wire logic [1:0] drop_short_first_line,
  output rx_gpio_pkg::framing_s [1:0] framing_out,
  output logic [1:0] setup_err
);
  import rx_gpio_pkg::*;

  main_state_s q;
  main_state_s d;
  logic [6:0] pin_lvl;
  logic [15:0] sel_word [NUM_PORTS];

  // choose one slot source from pins or frame sync
  function automatic logic pick_src(
    input logic [3:0] sel,
    input logic [6:0] pins,
    input logic ifs,
    input logic xfs
  );
    logic v;
    v = 1'b0;
    if (sel <= SRC_LAST_PIN) begin
      v = pins[sel[2:0]];
    end else if (sel == SRC_INT_SYNC) begin
      v = ifs;
    end else if (sel == SRC_EXT_SYNC) begin
      v = xfs;
    end
    return v;
  endfunction : pick_src

  // a disabled input reads as low, so a floating pin maps as zero
  assign pin_lvl = q.pin_s2 & ~q.in_dis;

  // slot k selector is nibble k of {select_b, select_a}
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      sel_word[p] = {q.slot_b[p], q.slot_a[p]};
    end
  end

  // next state: registers, synchronisers, frame timer, slot sampling
  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    // pins first pass two flops; stage one feeds stage two only
    d.pin_s1 = gpio_in;
    d.pin_s2 = q.pin_s1;
    d.xfs_s1 = ext_frame_sync;
    d.xfs_s2 = q.xfs_s1;
    // register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_PIN_IN_DIS: d.in_dis = reg_req.wdata[6:0];
        ADDR_PIN_PD_DIS: d.pd_dis = reg_req.wdata[6:0];
        ADDR_SLOT_A: d.slot_a[reg_req.port] = reg_req.wdata;
        ADDR_SLOT_B: d.slot_b[reg_req.port] = reg_req.wdata;
        ADDR_FRAMING_POL: begin
          d.pol[reg_req.port] = reg_req.wdata[1:0];
        end
        ADDR_FV_MIN: d.fv_min = reg_req.wdata;
        default: begin
        end
      endcase
    end
    // reads answer one cycle later; unmapped offsets read zero
    if (reg_req.rd) begin
      d.rd_valid = 1'b1;
      unique case (reg_req.addr)
        ADDR_PIN_IN_DIS: d.rd_data = {1'b0, q.in_dis};
        ADDR_PIN_PD_DIS: d.rd_data = {1'b0, q.pd_dis};
        ADDR_SLOT_A: d.rd_data = q.slot_a[reg_req.port];
        ADDR_SLOT_B: d.rd_data = q.slot_b[reg_req.port];
        ADDR_FRAMING_POL: d.rd_data = {6'h00, q.pol[reg_req.port]};
        ADDR_FV_MIN: d.rd_data = q.fv_min;
        default: d.rd_data = 8'h00;
      endcase
    end
    // pad controls follow the disables
    d.in_en = ~d.in_dis;
    d.pd_en = ~d.pd_dis;
    // no forward channel output here, so pins stay inputs
    d.oe_n = 7'h7f;
    d.pin_out = 7'h00;
    // free-running back channel frame of thirty bits
    d.strobe = 1'b0;
    if (q.frm_cnt == BC_FRAME_LAST) begin
      d.frm_cnt = 7'h00;
      d.strobe = 1'b1;
      // one sample per slot per frame
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int k = 0; k < NUM_SLOTS; k++) begin
          d.slots[p][k] = pick_src(sel_word[p][k*SLOT_SEL_W +: 4],
                                   pin_lvl, int_frame_sync, q.xfs_s2);
        end
      end
    end else begin
      d.frm_cnt = q.frm_cnt + 7'h01;
    end
  end

  // state register; pins come up as inputs with pulldowns on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.in_dis <= RST_PIN_IN_DIS;
      q.pd_dis <= RST_PIN_PD_DIS;
      q.in_en <= 7'h7f;
      q.pd_en <= 7'h7f;
      q.oe_n <= 7'h7f;
      q.fv_min <= RST_FV_MIN;
    end else begin
      q <= d;
    end
  end

  // per-port framing qualifiers; framing is only approximate when
  // several interleaved streams share a port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    rx_frame_qualify u_qual (
      .core_clk(core_clk),
      .rstn(rstn),
      .raw_in(raw_in[p]),
      .fv_pol(q.pol[p][POL_FV_BIT]),
      .lv_pol(q.pol[p][POL_LV_BIT]),
      .min_count(q.fv_min),
      .drop_short(drop_short_first_line[p]),
      .framing_out(framing_out[p]),
      .setup_err(setup_err[p])
    );
  end

  // outputs straight from the state register
  assign reg_rd_data = q.rd_data;
  assign reg_rd_valid = q.rd_valid;
  assign gpio_out = q.pin_out;
  assign gpio_oe_n = q.oe_n;
  assign pin_input_en = q.in_en;
  assign pin_pulldown_en = q.pd_en;
  assign bc_frame_strobe = q.strobe;
  assign bc_slots = q.slots;

  chk_pins_input: assert property (
    @(posedge core_clk) disable iff (!rstn)
    gpio_oe_n == 7'h7f)
    else $error("a gpio pin left input mode");

  chk_frame_period: assert property (
    @(posedge core_clk) disable iff (!rstn)
    bc_frame_strobe |=> !bc_frame_strobe [*8] ##112 bc_frame_strobe)
    else $error("back channel frame is not 120 cycles");

  chk_slot_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !bc_frame_strobe |-> $stable(bc_slots))
    else $error("slot changed between frame samples");

  chk_slot_pin: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (q.frm_cnt == BC_FRAME_LAST && sel_word[0][3:0] == 4'h2
      && sel_word[0][7:4] == 4'h2)
      |=> bc_slots[0][0] == $past(pin_lvl[2])
        && bc_slots[0][1] == bc_slots[0][0])
    else $error("shared pin not carried on both slots");

  chk_ext_sync: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (q.frm_cnt == BC_FRAME_LAST && sel_word[0][15:12] == SRC_EXT_SYNC)
      |=> bc_slots[0][3] == $past(q.xfs_s2))
    else $error("external frame sync not on its slot");

  chk_pulldown_ctl: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (reg_req.wr && reg_req.addr == ADDR_PIN_PD_DIS)
      |=> pin_pulldown_en == ~$past(reg_req.wdata[6:0]))
    else $error("pulldown does not follow its disable");

  cov_frame_sync_slot: cover property (
    @(posedge core_clk) disable iff (!rstn)
    bc_frame_strobe && bc_slots[0] != 4'h0);

  cov_pol_write: cover property (
    @(posedge core_clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == ADDR_FRAMING_POL);

endmodule : rx_port_gpio

/* raw_sync_src.sv */
// raw framing source standing in for the remote serializer's sync pins
// assumes the bench calls run_frame from one process per instance
`timescale 1ns/1ps
module raw_sync_src #(
  parameter bit INV = 1'b0
) (
  // clock
  input wire logic core_clk,
  // raw framing out
  output rx_gpio_pkg::raw_sync_s raw
);
  import rx_gpio_pkg::*;

  // idle level is the inactive level for the chosen polarity
  initial raw = '{vsync: INV, hsync: INV};

  // one frame: frame-valid lead, then lines of 8 cycles each
  task automatic run_frame(input int setup, input int lines);
    @(posedge core_clk);
    raw.vsync <= !INV;
    repeat (setup) @(posedge core_clk);
    for (int i = 0; i < lines; i++) begin
      raw.hsync <= !INV;
      repeat (8) @(posedge core_clk);
      raw.hsync <= INV;
      // last line end and frame end share one edge
      if (i == lines - 1) raw.vsync <= INV;
      repeat (16) @(posedge core_clk);
    end
  endtask : run_frame
endmodule : raw_sync_src

/* rx_port_gpio_and_frame_qualify_test.sv */
// self-checking bench for the receive-port gpio and framing block
// assumes raw_sync_src as far-side framing source, one 200 mhz clock
`timescale 1ns/1ps
module rx_port_gpio_and_frame_qualify_test;
  import rx_gpio_pkg::*;
  typedef struct {
    logic [7:0] addr;
    logic port;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_s;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_s reg_req = '0;
  logic [7:0] reg_rd_data;
  logic reg_rd_valid;
  logic [6:0] gpio_in = 7'h00;
  logic [6:0] gpio_out;
  logic [6:0] gpio_oe_n;
  logic [6:0] pin_input_en;
  logic [6:0] pin_pulldown_en;
  logic int_frame_sync = 1'b0;
  logic ext_frame_sync = 1'b0;
  logic bc_frame_strobe;
  logic [1:0][3:0] bc_slots;
  raw_sync_s raw0;
  raw_sync_s raw1;
  raw_sync_s [1:0] raw_in;
  logic [1:0] drop_short_first_line = 2'b01;
  framing_s [1:0] framing_out;
  logic [1:0] setup_err;
  framing_s [1:0] prev_q = '0;
  int errors = 0;
  int comparisons = 0;
  int lv_rise [2];
  int fv_rise [2];
  int err_cnt [2];
  int n;
  logic [7:0] d;
  row_s rows [9];

  assign raw_in = {raw1, raw0};

  rx_port_gpio dut (
    .core_clk(core_clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .pin_input_en(pin_input_en), .pin_pulldown_en(pin_pulldown_en),
    .int_frame_sync(int_frame_sync), .ext_frame_sync(ext_frame_sync),
    .bc_frame_strobe(bc_frame_strobe), .bc_slots(bc_slots),
    .raw_in(raw_in), .drop_short_first_line(drop_short_first_line),
    .framing_out(framing_out), .setup_err(setup_err)
  );
  // port 1 source is inverted, its polarity register undoes that
  raw_sync_src #(.INV(1'b0)) src0 (.core_clk(core_clk), .raw(raw0));
  raw_sync_src #(.INV(1'b1)) src1 (.core_clk(core_clk), .raw(raw1));

  initial forever #2.5 core_clk = ~core_clk;

  // edge counters on the qualified framing, cleared off the edge
  always @(posedge core_clk) begin
    for (int p = 0; p < 2; p++) begin
      if (framing_out[p].line_valid && !prev_q[p].line_valid) lv_rise[p]++;
      if (framing_out[p].frame_valid && !prev_q[p].frame_valid) fv_rise[p]++;
      if (setup_err[p]) err_cnt[p]++;
    end
    prev_q <= framing_out;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic p,
                        input logic [7:0] w);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, port: p, addr: a, wdata: w};
    @(posedge core_clk);
    reg_req <= '0;
  endtask : reg_wr

  // read data is looked at in the single cycle that valid stands
  task automatic reg_rd(input logic [7:0] a, input logic p,
                        output logic [7:0] q);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, port: p, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '0;
    q = 8'hxx;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (reg_rd_valid === 1'b1) begin
        q = reg_rd_data;
        break;
      end
      @(posedge core_clk);
    end
  endtask : reg_rd

  task automatic wait_strobe(output int cyc);
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1;
      cyc++;
    end while (bc_frame_strobe !== 1'b1 && cyc < 200);
  endtask : wait_strobe

  task automatic clr_cnt;
    lv_rise = '{0, 0};
    fv_rise = '{0, 0};
    err_cnt = '{0, 0};
  endtask : clr_cnt

  task automatic chk_port(input int p, input int lv, input int er);
    chk("fv_rises", 8'h01, 8'(fv_rise[p]));
    chk("lv_rises", 8'(lv), 8'(lv_rise[p]));
    chk("setup_errs", 8'(er), 8'(err_cnt[p]));
  endtask : chk_port

  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // the tests take about 720 cycles; the limit of 10000 allows over ten times that
  initial begin
    #50000;
    errors++;
    final_report();
  end

  initial begin
    rows = '{'{8'h0f, 1'b0, 8'hff, 8'h7f}, '{8'hbe, 1'b0, 8'h55, 8'h55},
             '{8'h6e, 1'b0, 8'h22, 8'h22}, '{8'h6e, 1'b1, 8'h59, 8'h59},
             '{8'h6f, 1'b0, 8'h87, 8'h87}, '{8'h6f, 1'b1, 8'h06, 8'h06},
             '{8'h7c, 1'b1, 8'hff, 8'h03}, '{8'hbc, 1'b0, 8'h05, 8'h05},
             '{8'h33, 1'b0, 8'haa, 8'h00}};
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("gpio_oe_n", 8'h7f, {1'b0, gpio_oe_n});
    chk("pin_input_en", 8'h7f, {1'b0, pin_input_en});
    chk("pin_pulldown_en", 8'h7f, {1'b0, pin_pulldown_en});
    reg_rd(ADDR_FV_MIN, 1'b0, d);
    chk("fv_min_reset", 8'h80, d);
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].port, rows[i].wd);
      reg_rd(rows[i].addr, rows[i].port, d);
      chk("reg_read", rows[i].exp, d);
    end
    chk("pin_input_en", 8'h00, {1'b0, pin_input_en});
    chk("pin_pulldown_en", 8'h2a, {1'b0, pin_pulldown_en});
    reg_rd(ADDR_FRAMING_POL, 1'b0, d);
    chk("port0_pol", 8'h00, d);
    reg_rd(ADDR_SLOT_A, 1'b1, d);
    chk("port1_slot_a", 8'h59, d);
    reg_wr(ADDR_PIN_IN_DIS, 1'b0, 8'h00);
    // pins 2 and 6 high, both frame syncs high
    @(posedge core_clk);
    gpio_in <= 7'h44;
    int_frame_sync <= 1'b1;
    ext_frame_sync <= 1'b1;
    wait_strobe(n);
    wait_strobe(n);
    wait_strobe(n);
    chk("strobe_gap", 8'h78, 8'(n));
    chk("port0_slots", 8'h0f, {4'h0, bc_slots[0]});
    chk("port1_slots", 8'h04, {4'h0, bc_slots[1]});
    reg_wr(ADDR_PIN_IN_DIS, 1'b0, 8'h04);
    wait_strobe(n);
    wait_strobe(n);
    chk("port0_slots", 8'h0c, {4'h0, bc_slots[0]});
    // setup of 5 equals the minimum, so both first lines are short
    clr_cnt();
    fork
      src0.run_frame(5, 2);
      src1.run_frame(5, 2);
    join
    repeat (4) @(posedge core_clk);
    #1;
    chk_port(0, 1, 1);
    chk_port(1, 2, 1);
    clr_cnt();
    fork
      src0.run_frame(6, 2);
      src1.run_frame(6, 2);
    join
    repeat (4) @(posedge core_clk);
    #1;
    chk_port(0, 2, 0);
    chk_port(1, 2, 0);
    final_report();
  end
endmodule : rx_port_gpio_and_frame_qualify_test
